// ===== verilog/afl_lookup.sv
// destination lookup of the switch: hash, bucket read, match and forwarding decision
// What this block does
// RL1 - hash destination address with VLAN id into a key and search the table
// RL2 - no matching entry: flood, unless lookup-fail forwarding applies
// RL3 - vlan aware on: key is address plus VLAN; off: address only
// RL4 - unicast matching multiport address forwards by multiport setting, before lookup
// RL5 - unicast lookup uses low ten hash bits as bucket pointer
// RL6 - valid entry with matching key gives the destination port
// RL7 - destination port equal to source port: frame is dropped
// RL8 - unicast miss with unicast fail forward on: use unicast fail map
// RL9 - entry holds VLAN, valid, static, age, class, port and 48-bit address
// RL10 - static entries are software kept and never aged
// RL11 - accessed dynamic entry gets its age flag set to one
// RL12 - traffic class from entry honoured only for static entries
// RL13 - reserved multicast 01-80-C2-00-00-00..2F diverted before anything else
// RL14 - multicast matching multiport address forwarded without table lookup
// RL15 - multicast lookup uses low ten hash bits for the bucket
// RL16 - valid matching multicast entry gives its port mask
// RL17 - multicast mask is nine bits, one bit per port
// RL18 - multicast miss with multicast fail forward on: use fail map
// RL19 - two multicast group types, each with its own fail map
// RL20 - unresolved broadcast is flooded; unresolved multicast too, unless multicast fail forward is on
// RL21 - static multicast entries ignore age and are never aged
// RL22 - four bins per bucket, bins 0-1 read first, 2-3 second
// RL23 - hash is CCITT CRC-16, low ten bits index the table
// RL24 - one decision per frame; fail map limited to eligible, minus source
// RL25 - several matching bins: lowest-numbered one wins
`timescale 1ns/1ns
`include "afl_map.svh"

module afl_lookup
  import afl_pkg::*;
#(
  parameter int NPORT  = 9,
  parameter int PORT_W = 4,
  parameter int IDX_W  = 10,
  parameter int VID_W  = 12
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  // apb register port
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // frame request from ingress
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [47:0]          req_da,
  input  wire logic [VID_W-1:0]     req_vid,
  input  wire logic [PORT_W-1:0]    req_src_port,
  // decision towards egress queues
  output logic                      rsp_valid,
  output logic [2:0]                rsp_kind,
  output logic [PORT_W-1:0]         rsp_port,
  output logic [NPORT-1:0]          rsp_mask,
  output logic [2:0]                rsp_tc,
  output logic                      rsp_tc_valid,
  // table read port, data one cycle after the request
  output logic                      tbl_rd_en,
  output logic [IDX_W-1:0]          tbl_rd_idx,
  output logic                      tbl_rd_half,
  input  wire logic [`AFL_ENT_W-1:0] tbl_rd_even,
  input  wire logic [`AFL_ENT_W-1:0] tbl_rd_odd,
  // age refresh of a hit dynamic entry
  output logic                      tbl_age_wr,
  output logic [IDX_W-1:0]          tbl_age_idx,
  output logic [1:0]                tbl_age_bin
);

  // crc over address, then vid when the key includes it
  function automatic logic [15:0] afl_crc(input logic [`AFL_KEY_W-1:0] key,
                                          input logic use_vid);
    logic [15:0] c;
    logic        fb;
    c = `AFL_CRC_INIT;
    for (int i = `AFL_KEY_W - 1; i >= 0; i--) begin
      if (use_vid || i >= `AFL_VID_BITS) begin
        fb = c[15] ^ key[i];
        c  = {c[14:0], 1'b0};
        if (fb) begin
          c = c ^ `AFL_CRC_POLY;
        end
      end
    end
    return c;
  endfunction

  function automatic logic afl_match(input logic [`AFL_ENT_W-1:0] e,
                                     input logic [47:0] da,
                                     input logic [VID_W-1:0] vid,
                                     input logic aware);
    return e[`AFL_E_VALID] && (e[`AFL_E_MAC] == da) &&
           (!aware || (e[`AFL_E_VID] == vid));
  endfunction

  afl_state_t               state_ff;
  afl_state_t               nxt_state;
  logic [`AFL_CTRL_W-1:0]   ctrl_ff;
  logic [NPORT-1:0]         elig_ff;
  logic [NPORT-1:0]         ucfail_ff;
  logic [NPORT-1:0]         mcfail0_ff;
  logic [NPORT-1:0]         mcfail1_ff;
  logic [47:0]              mpa_ff;
  logic [NPORT-1:0]         mpmap_ff;
  logic [15:0]              hitcnt_ff;
  logic                     last_hit_ff;
  logic [47:0]              da_ff;
  logic [VID_W-1:0]         vid_ff;
  logic [PORT_W-1:0]        src_ff;
  logic [IDX_W-1:0]         idx_ff;
  logic [`AFL_ENT_W-1:0]    bin_ff [2];
  logic [`AFL_ENT_W-1:0]    cur_bin [4];
  logic                     rsp_valid_ff;
  afl_kind_t                kind_ff;
  logic [PORT_W-1:0]        port_ff;
  logic [NPORT-1:0]         mask_ff;
  logic [2:0]               tc_ff;
  logic                     tcv_ff;
  logic                     age_wr_ff;
  logic [1:0]               age_bin_ff;
  logic [31:0]              prdata_ff;
  logic                     pslverr_ff;

  logic                     aware;
  logic [15:0]              hash;
  logic                     is_mc;
  logic                     is_rsvd;
  logic                     is_mport;
  logic                     mc_type1;
  logic [NPORT-1:0]         src_bit;
  logic [NPORT-1:0]         allowed;
  logic                     hit;
  logic [1:0]               hbin;
  logic [`AFL_ENT_W-1:0]    hent;
  logic                     dec_load;
  afl_kind_t                nxt_kind;
  logic [PORT_W-1:0]        nxt_port;
  logic [NPORT-1:0]         nxt_mask;
  logic [2:0]               nxt_tc;
  logic                     nxt_tcv;
  logic                     apb_wr;
  logic                     apb_setup;

  assign aware   = ctrl_ff[`AFL_CTRL_VLAN];
  // see RL1, RL3, RL23
  assign hash    = afl_crc({da_ff, vid_ff}, aware);
  assign is_mc   = da_ff[`AFL_DA_GROUP];
  // see RL13
  assign is_rsvd = is_mc && (da_ff[47:8] == `AFL_RSVD_PFX) && (da_ff[7:0] <= `AFL_RSVD_LAST);
  // see RL4, RL14
  assign is_mport = ctrl_ff[`AFL_CTRL_MPORT] && (da_ff == mpa_ff);
  // see RL19
  assign mc_type1 = (da_ff[47:24] == `AFL_IPV4_PFX) || (da_ff[47:32] == `AFL_IPV6_PFX);
  assign src_bit  = NPORT'(1) << src_ff;
  // see RL24
  assign allowed  = elig_ff & ~src_bit;

  // bins 0-1 held from the first read, bins 2-3 arrive now; see RL22
  always_comb begin
    cur_bin[0] = bin_ff[0];
    cur_bin[1] = bin_ff[1];
    cur_bin[2] = tbl_rd_even;
    cur_bin[3] = tbl_rd_odd;
  end

  // search from the top so the lowest matching bin is left; see RL25
  always_comb begin
    hit  = 1'b0;
    hbin = 2'b00;
    for (int b = 3; b >= 0; b--) begin
      if (afl_match(cur_bin[b], da_ff, vid_ff, aware)) begin
        hit  = 1'b1;
        hbin = 2'(b);
      end
    end
    hent = cur_bin[hbin];
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      AFL_IDLE: begin
        if (req_valid) begin
          nxt_state = AFL_CLASS;
        end
      end
      AFL_CLASS: begin
        if (is_rsvd || is_mport) begin
          nxt_state = AFL_DONE;
        end else begin
          nxt_state = AFL_PAIR0;
        end
      end
      AFL_PAIR0: nxt_state = AFL_PAIR1;
      AFL_PAIR1: nxt_state = AFL_DONE;
      AFL_DONE:  nxt_state = AFL_IDLE;
      default:   nxt_state = AFL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= AFL_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign req_ready = (state_ff == AFL_IDLE);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      da_ff  <= '0;
      vid_ff <= '0;
      src_ff <= '0;
    end else if (req_valid && req_ready) begin
      da_ff  <= req_da;
      vid_ff <= req_vid;
      src_ff <= req_src_port;
    end
  end

  // table read: low hash bits pick the bucket; see RL5, RL15, RL22
  assign tbl_rd_en   = ((state_ff == AFL_CLASS) && !is_rsvd && !is_mport) ||
                       (state_ff == AFL_PAIR0);
  assign tbl_rd_idx  = (state_ff == AFL_CLASS) ? hash[IDX_W-1:0] : idx_ff;
  assign tbl_rd_half = (state_ff == AFL_PAIR0);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idx_ff    <= '0;
      bin_ff[0] <= '0;
      bin_ff[1] <= '0;
    end else begin
      if (state_ff == AFL_CLASS) begin
        idx_ff <= hash[IDX_W-1:0];
      end
      if (state_ff == AFL_PAIR0) begin
        bin_ff[0] <= tbl_rd_even;
        bin_ff[1] <= tbl_rd_odd;
      end
    end
  end

  assign dec_load = ((state_ff == AFL_CLASS) && (is_rsvd || is_mport)) ||
                    (state_ff == AFL_PAIR1);
  // one decision per frame, reserved first, then multiport, then table; see RL24
  always_comb begin
    nxt_kind = AFL_FWD_FLOOD;
    nxt_port = '0;
    nxt_mask = allowed;
    nxt_tc   = '0;
    nxt_tcv  = 1'b0;
    if (state_ff == AFL_CLASS) begin
      if (is_rsvd) begin
        nxt_kind = AFL_FWD_RSVD; // see RL13
        nxt_mask = '0;
      end else begin
        nxt_kind = AFL_FWD_MASK; // see RL4, RL14
        nxt_mask = mpmap_ff & allowed;
      end
    end else if (hit) begin
      // static-only class; see RL9, RL12
      nxt_tc  = hent[`AFL_E_TC];
      nxt_tcv = hent[`AFL_E_STATIC];
      if (is_mc) begin
        nxt_kind = AFL_FWD_MASK; // see RL16, RL17
        nxt_mask = hent[`AFL_E_MASK] & ~src_bit;
      end else if (hent[`AFL_E_PORT] == src_ff) begin
        nxt_kind = AFL_FWD_DROP; // see RL7
        nxt_mask = '0;
      end else begin
        nxt_kind = AFL_FWD_PORT; // see RL6
        nxt_port = hent[`AFL_E_PORT];
        nxt_mask = NPORT'(1) << hent[`AFL_E_PORT];
      end
    end else if (!is_mc && ctrl_ff[`AFL_CTRL_UCFAIL]) begin
      nxt_kind = AFL_FWD_MASK; // see RL8
      nxt_mask = ucfail_ff & allowed;
    end else if (is_mc && (da_ff != `AFL_BCAST) && ctrl_ff[`AFL_CTRL_MCFAIL]) begin
      nxt_kind = AFL_FWD_MASK; // see RL18, RL19
      nxt_mask = (mc_type1 ? mcfail1_ff : mcfail0_ff) & allowed;
    end
    // anything else stays flood to eligible ports; see RL2, RL20
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_ff <= 1'b0;
      kind_ff      <= AFL_FWD_FLOOD;
      port_ff      <= '0;
      mask_ff      <= '0;
      tc_ff        <= '0;
      tcv_ff       <= 1'b0;
    end else begin
      rsp_valid_ff <= (state_ff == AFL_DONE);
      if (dec_load) begin
        kind_ff <= nxt_kind;
        port_ff <= nxt_port;
        mask_ff <= nxt_mask;
        tc_ff   <= nxt_tc;
        tcv_ff  <= nxt_tcv;
      end
    end
  end
  assign rsp_valid    = rsp_valid_ff;
  assign rsp_kind     = kind_ff;
  assign rsp_port     = port_ff;
  assign rsp_mask     = mask_ff;
  assign rsp_tc       = tc_ff;
  assign rsp_tc_valid = tcv_ff;

  // only dynamic hits refresh age; static ones keep theirs untouched
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      age_wr_ff   <= 1'b0;
      age_bin_ff  <= '0;
      last_hit_ff <= 1'b0;
      hitcnt_ff   <= '0;
    end else begin
      age_wr_ff <= (state_ff == AFL_PAIR1) && hit && !hent[`AFL_E_STATIC]; // see RL10, RL11, RL21
      if (state_ff == AFL_PAIR1) begin
        age_bin_ff  <= hbin;
        last_hit_ff <= hit;
        if (hit) begin
          hitcnt_ff <= hitcnt_ff + 16'h0001;
        end
      end else if (state_ff == AFL_CLASS) begin
        last_hit_ff <= 1'b0;
      end
    end
  end

  assign tbl_age_wr  = age_wr_ff;
  assign tbl_age_idx = idx_ff;
  assign tbl_age_bin = age_bin_ff;

  // apb: read data is captured in the setup cycle so it comes from a flop
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign prdata    = prdata_ff;
  assign pslverr   = pslverr_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff    <= `AFL_CTRL_RST;
      elig_ff    <= `AFL_ELIG_RST;
      ucfail_ff  <= `AFL_MAP_RST;
      mcfail0_ff <= `AFL_MAP_RST;
      mcfail1_ff <= `AFL_MAP_RST;
      mpa_ff     <= '0;
      mpmap_ff   <= `AFL_MAP_RST;
    end else if (apb_wr) begin
      case (paddr)
        `AFL_OFS_CTRL:    ctrl_ff    <= pwdata[`AFL_CTRL_W-1:0];
        `AFL_OFS_ELIG:    elig_ff    <= pwdata[NPORT-1:0];
        `AFL_OFS_UCFAIL:  ucfail_ff  <= pwdata[NPORT-1:0];
        `AFL_OFS_MCFAIL0: mcfail0_ff <= pwdata[NPORT-1:0];
        `AFL_OFS_MCFAIL1: mcfail1_ff <= pwdata[NPORT-1:0];
        `AFL_OFS_MPA_LO:  mpa_ff[31:0]  <= pwdata;
        `AFL_OFS_MPA_HI:  mpa_ff[47:32] <= pwdata[15:0];
        `AFL_OFS_MPMAP:   mpmap_ff   <= pwdata[NPORT-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else if (apb_setup) begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
      case (paddr)
        `AFL_OFS_CTRL:    prdata_ff[`AFL_CTRL_W-1:0] <= ctrl_ff;
        `AFL_OFS_ELIG:    prdata_ff[NPORT-1:0] <= elig_ff;
        `AFL_OFS_UCFAIL:  prdata_ff[NPORT-1:0] <= ucfail_ff;
        `AFL_OFS_MCFAIL0: prdata_ff[NPORT-1:0] <= mcfail0_ff;
        `AFL_OFS_MCFAIL1: prdata_ff[NPORT-1:0] <= mcfail1_ff;
        `AFL_OFS_MPA_LO:  prdata_ff <= mpa_ff[31:0];
        `AFL_OFS_MPA_HI:  prdata_ff[15:0] <= mpa_ff[47:32];
        `AFL_OFS_MPMAP:   prdata_ff[NPORT-1:0] <= mpmap_ff;
        `AFL_OFS_STATUS: begin
          prdata_ff[`AFL_ST_KIND] <= kind_ff;
          prdata_ff[`AFL_ST_PORT] <= port_ff;
          prdata_ff[`AFL_ST_MASK] <= mask_ff;
          prdata_ff[`AFL_ST_HIT]  <= last_hit_ff;
        end
        `AFL_OFS_HITCNT:  prdata_ff[15:0] <= hitcnt_ff;
        default:          pslverr_ff <= 1'b1;
      endcase
    end
  end
endmodule

// ===== verilog/afl_map.svh
// register offsets, field positions, reset values and constants of the forwarding lookup
`ifndef AFL_MAP_SVH
`define AFL_MAP_SVH

`define AFL_OFS_CTRL      8'h00
`define AFL_OFS_ELIG      8'h04
`define AFL_OFS_UCFAIL    8'h08
`define AFL_OFS_MCFAIL0   8'h0C
`define AFL_OFS_MCFAIL1   8'h10
`define AFL_OFS_MPA_LO    8'h14
`define AFL_OFS_MPA_HI    8'h18
`define AFL_OFS_MPMAP     8'h1C
`define AFL_OFS_STATUS    8'h20
`define AFL_OFS_HITCNT    8'h24

`define AFL_CTRL_VLAN     0
`define AFL_CTRL_MPORT    1
`define AFL_CTRL_UCFAIL   2
`define AFL_CTRL_MCFAIL   3
`define AFL_CTRL_W        4
`define AFL_CTRL_RST      4'h0
`define AFL_ELIG_RST      9'h1FF
`define AFL_MAP_RST       9'h000

`define AFL_E_MAC         47:0
`define AFL_E_PORT        51:48
`define AFL_E_MASK        56:48
`define AFL_E_TC          59:57
`define AFL_E_AGE         60
`define AFL_E_STATIC      61
`define AFL_E_VALID       62
`define AFL_E_VID         74:63
`define AFL_ENT_W         75

`define AFL_ST_KIND       2:0
`define AFL_ST_PORT       7:4
`define AFL_ST_MASK       16:8
`define AFL_ST_HIT        24

`define AFL_DA_GROUP      40
`define AFL_RSVD_PFX      40'h0180C20000
`define AFL_RSVD_LAST     8'h2F
`define AFL_IPV4_PFX      24'h01005E
`define AFL_IPV6_PFX      16'h3333
`define AFL_BCAST         48'hFFFFFFFFFFFF

`define AFL_CRC_POLY      16'h1021
`define AFL_CRC_INIT      16'h0000
`define AFL_KEY_W         60
`define AFL_VID_BITS      12

`endif

// ===== verilog/afl_pkg.sv
// types shared by the forwarding lookup
package afl_pkg;
  typedef enum logic [2:0] {
    AFL_IDLE  = 3'b000,
    AFL_CLASS = 3'b001,
    AFL_PAIR0 = 3'b010,
    AFL_PAIR1 = 3'b011,
    AFL_DONE  = 3'b100
  } afl_state_t;

  typedef enum logic [2:0] {
    AFL_FWD_PORT  = 3'b000,
    AFL_FWD_MASK  = 3'b001,
    AFL_FWD_DROP  = 3'b010,
    AFL_FWD_FLOOD = 3'b011,
    AFL_FWD_RSVD  = 3'b100
  } afl_kind_t;
endpackage

// ===== tb/afl_lookup_asserts.sv
// concurrent checks on the ports of the forwarding lookup
`timescale 1ns/1ns
`include "afl_map.svh"

module afl_lookup_asserts
  import afl_pkg::*;
#(
  parameter int NPORT  = 9,
  parameter int PORT_W = 4,
  parameter int IDX_W  = 10
) (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic [47:0]       req_da,
  input wire logic [PORT_W-1:0] req_src_port,
  input wire logic              rsp_valid,
  input wire logic [2:0]        rsp_kind,
  input wire logic [PORT_W-1:0] rsp_port,
  input wire logic [NPORT-1:0]  rsp_mask,
  input wire logic              rsp_tc_valid,
  input wire logic              tbl_rd_en,
  input wire logic [IDX_W-1:0]  tbl_rd_idx,
  input wire logic              tbl_rd_half,
  input wire logic              tbl_age_wr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic [PORT_W-1:0] src_ff;
  wire               accept = req_valid && req_ready;

  // the source port is only on the bus at the accept edge, so keep it for the answer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      src_ff <= '0;
    end else if (accept) begin
      src_ff <= req_src_port;
    end
  end

  sequence s_rsvd;
    accept && req_da[47:8] == `AFL_RSVD_PFX && req_da[7:0] <= `AFL_RSVD_LAST;
  endsequence
  sequence s_pair;
    tbl_rd_en && !tbl_rd_half ##1 tbl_rd_en && tbl_rd_half;
  endsequence

  property p_rsvd;
    s_rsvd |-> ##3 (rsp_valid && rsp_kind == AFL_FWD_RSVD && rsp_mask == '0);
  endproperty
  property p_pair;
    tbl_rd_en && !tbl_rd_half |=> tbl_rd_en && tbl_rd_half && $stable(tbl_rd_idx);
  endproperty
  property p_decide;
    s_pair |-> ##3 rsp_valid;
  endproperty
  property p_no_self;
    rsp_valid && rsp_kind == AFL_FWD_PORT |-> rsp_port != src_ff;
  endproperty
  property p_src_out;
    rsp_valid |-> !rsp_mask[src_ff];
  endproperty
  property p_drop;
    rsp_valid && rsp_kind == AFL_FWD_DROP |-> rsp_mask == '0;
  endproperty
  property p_age;
    tbl_age_wr |-> $past(tbl_rd_half, 2) ##1 rsp_valid;
  endproperty
  property p_busy;
    accept |=> !req_ready [*2];
  endproperty
  property p_tc;
    rsp_valid && rsp_kind == AFL_FWD_FLOOD |-> !rsp_tc_valid;
  endproperty

  a_rsvd: assert property (p_rsvd) else $error("reserved address not diverted");
  a_pair: assert property (p_pair) else $error("bucket halves not read in pair");
  a_decide: assert property (p_decide) else $error("no decision after bucket read");
  a_no_self: assert property (p_no_self) else $error("port decision to source");
  a_src_out: assert property (p_src_out) else $error("mask holds source port");
  a_drop: assert property (p_drop) else $error("drop with nonzero mask");
  a_age: assert property (p_age) else $error("age refresh out of step");
  a_busy: assert property (p_busy) else $error("request taken while busy");
  a_tc: assert property (p_tc) else $error("class valid on flood");
endmodule

// ===== tb/afl_tbl_model.sv
// behavioural table memory behind the lookup's read and age ports
`timescale 1ns/1ns
`include "afl_map.svh"

module afl_tbl_model (
  input wire logic        clk_sys,
  input wire logic        tbl_rd_en,
  input wire logic [9:0]  tbl_rd_idx,
  input wire logic        tbl_rd_half,
  output logic     [74:0] tbl_rd_even,
  output logic     [74:0] tbl_rd_odd,
  input wire logic        tbl_age_wr,
  input wire logic [9:0]  tbl_age_idx,
  input wire logic [1:0]  tbl_age_bin
);
  logic [74:0] mem [int];
  int          age_cnt = 0;

  // empty bins carry all-ones junk with valid low, so a match that skips valid shows up
  function automatic logic [74:0] peek(input int k);
    return mem.exists(k) ? mem[k] : ~(75'h1 << `AFL_E_VALID);
  endfunction

  task automatic load(input int k, input logic [74:0] e);
    mem[k] = e;
  endtask

  always @(posedge clk_sys) begin
    if (tbl_rd_en) begin
      tbl_rd_even <= peek({tbl_rd_idx, tbl_rd_half, 1'b0});
      tbl_rd_odd  <= peek({tbl_rd_idx, tbl_rd_half, 1'b1});
    end else begin
      tbl_rd_even <= ~tbl_rd_even;
      tbl_rd_odd  <= ~tbl_rd_odd;
    end
    if (tbl_age_wr) begin
      mem[{tbl_age_idx, tbl_age_bin}][`AFL_E_AGE] = 1'b1;
      age_cnt++;
    end
  end
endmodule

// ===== tb/test_arl_forwarding_lookup.sv
// self-checking bench of the forwarding lookup
`timescale 1ns/1ns
`include "afl_map.svh"

module test_arl_forwarding_lookup import afl_pkg::*;;
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [47:0] da;
    logic [11:0] vid;
    logic [3:0]  src;
    logic [2:0]  kind;
    logic [8:0]  mask;
    logic [3:0]  port;
    logic        tcv;
  } afl_row_t;

  localparam logic [47:0] ua = 48'h001122334455;
  localparam logic [47:0] ud = 48'h0A0B0C0D0E0F;
  localparam logic [47:0] ma = 48'h010000000001;
  localparam logic [47:0] un = 48'h00AA00BB00CC;

  logic        clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0, prdata;
  logic        pready, pslverr, req_ready, rsp_valid, rsp_tc_valid, tbl_rd_en, tbl_rd_half;
  logic        req_valid = 1'b0, tbl_age_wr;
  logic [47:0] req_da  = 48'h0;
  logic [11:0] req_vid = 12'h000;
  logic [3:0]  req_src_port = 4'h0, rsp_port;
  logic [2:0]  rsp_kind, rsp_tc;
  logic [8:0]  rsp_mask;
  logic [9:0]  tbl_rd_idx, tbl_age_idx;
  logic [74:0] tbl_rd_even, tbl_rd_odd;
  logic [1:0]  tbl_age_bin;
  int          n_errors = 0, checks = 0, cycles = 0;

  afl_row_t rows [16] = '{
    '{4'h0, ua, 12'h000, 4'h1, AFL_FWD_PORT, 9'h008, 4'h3, 1'b1},
    '{4'h0, ua, 12'h000, 4'h3, AFL_FWD_DROP, 9'h000, 4'h0, 1'b0},
    '{4'h1, ua, 12'h005, 4'h0, AFL_FWD_PORT, 9'h040, 4'h6, 1'b1},
    '{4'h1, ua, 12'h006, 4'h0, AFL_FWD_FLOOD, 9'h1FE, 4'h0, 1'b0},
    '{4'h0, ud, 12'h000, 4'h0, AFL_FWD_PORT, 9'h004, 4'h2, 1'b0},
    '{4'h0, un, 12'h000, 4'h0, AFL_FWD_FLOOD, 9'h1FE, 4'h0, 1'b0},
    '{4'h4, un, 12'h000, 4'h0, AFL_FWD_MASK, 9'h0F2, 4'h0, 1'b0},
    '{4'h0, ma, 12'h000, 4'h0, AFL_FWD_MASK, 9'h1A4, 4'h0, 1'b0},
    '{4'h8, 48'h012200000001, 12'h000, 4'h1, AFL_FWD_MASK, 9'h0C0, 4'h0, 1'b0},
    '{4'h8, 48'h01005E010203, 12'h000, 4'h4, AFL_FWD_MASK, 9'h020, 4'h0, 1'b0},
    '{4'h0, 48'h012200000001, 12'h000, 4'h1, AFL_FWD_FLOOD, 9'h1FD, 4'h0, 1'b0},
    '{4'h8, 48'hFFFFFFFFFFFF, 12'h000, 4'h2, AFL_FWD_FLOOD, 9'h1FB, 4'h0, 1'b0},
    '{4'h8, 48'h0180C200002F, 12'h000, 4'h0, AFL_FWD_RSVD, 9'h000, 4'h0, 1'b0},
    '{4'h2, 48'h0180C2000000, 12'h000, 4'h0, AFL_FWD_RSVD, 9'h000, 4'h0, 1'b0},
    '{4'h0, 48'h0180C2000030, 12'h000, 4'h0, AFL_FWD_FLOOD, 9'h1FE, 4'h0, 1'b0},
    '{4'h2, ua, 12'h000, 4'h1, AFL_FWD_MASK, 9'h0F0, 4'h0, 1'b0}
  };

  always #2 clk_sys = ~clk_sys;

  afl_lookup afl_lookup_i (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .req_valid, .req_ready, .req_da, .req_vid, .req_src_port,
    .rsp_valid, .rsp_kind, .rsp_port, .rsp_mask, .rsp_tc, .rsp_tc_valid, .tbl_rd_en,
    .tbl_rd_idx, .tbl_rd_half, .tbl_rd_even, .tbl_rd_odd, .tbl_age_wr, .tbl_age_idx,
    .tbl_age_bin);
  afl_tbl_model afl_tbl_model_i (.clk_sys, .tbl_rd_en, .tbl_rd_idx, .tbl_rd_half,
    .tbl_rd_even, .tbl_rd_odd, .tbl_age_wr, .tbl_age_idx, .tbl_age_bin);

  task automatic finish_test;
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // bucket index worked out independently: crc over address, then vid when aware
  function automatic logic [9:0] hidx(input logic [47:0] da, input logic [11:0] vid,
                                      input logic aw);
    logic [15:0] c;
    logic [59:0] k;
    logic        fb;
    c = `AFL_CRC_INIT;
    k = {da, vid};
    for (int i = 59; i >= (aw ? 0 : 12); i--) begin
      fb = c[15] ^ k[i];
      c = {c[14:0], 1'b0} ^ (fb ? `AFL_CRC_POLY : 16'h0000);
    end
    return c[9:0];
  endfunction

  function automatic logic [74:0] ent(input logic [47:0] mac, input logic [8:0] fld,
                                      input logic [2:0] tc, input logic st,
                                      input logic [11:0] vid);
    return {vid, 1'b1, st, 1'b0, tc, fld, mac};
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic send(input afl_row_t r);
    int n;
    req_valid    <= 1'b1;
    req_da       <= r.da;
    req_vid      <= r.vid;
    req_src_port <= r.src;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp_valid !== 1'b1 && n < 20);
    chk("rsp_valid", 1'b1, rsp_valid);
    chk("rsp_kind", r.kind, rsp_kind);
    chk("rsp_mask", r.mask, rsp_mask);
    if (r.kind == AFL_FWD_PORT) begin
      chk("rsp_port", r.port, rsp_port);
      chk("rsp_tc_valid", r.tcv, rsp_tc_valid);
    end
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      finish_test;
    end
  end

  initial begin
    logic [31:0] rd;
    logic        er;
    repeat (20) @(posedge clk_sys);
    chk("req_ready", 1'b1, req_ready);
    chk("rsp_kind", AFL_FWD_FLOOD, rsp_kind);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, `AFL_OFS_CTRL, 32'h0, rd, er);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, `AFL_OFS_ELIG, 32'h0, rd, er);
    chk("elig", 32'h1FF, rd);
    apb(1'b0, 8'h28, 32'h0, rd, er);
    chk("unmapped_err", 1'b1, er);
    apb(1'b1, `AFL_OFS_UCFAIL, 32'h0F3, rd, er);
    apb(1'b1, `AFL_OFS_MCFAIL0, 32'h0C0, rd, er);
    apb(1'b1, `AFL_OFS_MCFAIL1, 32'h030, rd, er);
    apb(1'b1, `AFL_OFS_MPA_LO, ua[31:0], rd, er);
    apb(1'b1, `AFL_OFS_MPA_HI, {16'h0, ua[47:32]}, rd, er);
    apb(1'b1, `AFL_OFS_MPMAP, 32'h0F0, rd, er);
    afl_tbl_model_i.load(hidx(ua, 12'h000, 1'b0) * 4, ent(ua, 9'h003, 3'h5, 1'b1, 12'h000));
    afl_tbl_model_i.load(hidx(ua, 12'h005, 1'b1) * 4 + 1, ent(ua, 9'h006, 3'h1, 1'b1, 12'h005));
    afl_tbl_model_i.load(hidx(ud, 12'h000, 1'b0) * 4 + 2, ent(ud, 9'h002, 3'h0, 1'b0, 12'h000));
    afl_tbl_model_i.load(hidx(ud, 12'h000, 1'b0) * 4 + 3, ent(ud, 9'h007, 3'h0, 1'b0, 12'h000));
    afl_tbl_model_i.load(hidx(ma, 12'h000, 1'b0) * 4 + 3, ent(ma, 9'h1A5, 3'h0, 1'b1, 12'h000));
    foreach (rows[i]) begin
      apb(1'b1, `AFL_OFS_CTRL, {28'h0, rows[i].ctrl}, rd, er);
      send(rows[i]);
    end
    chk("age_writes", 48'd1, 48'(afl_tbl_model_i.age_cnt));
    chk("age_bin2", 1'b1, afl_tbl_model_i.mem[hidx(ud, 12'h000, 1'b0) * 4 + 2][`AFL_E_AGE]);
    apb(1'b0, `AFL_OFS_HITCNT, 32'h0, rd, er);
    chk("hitcnt", 32'h5, rd);
    apb(1'b1, `AFL_OFS_CTRL, 32'h0, rd, er);
    send(rows[0]);
    chk("rsp_tc", 3'h5, rsp_tc);
    // narrowed eligible set and two requests back to back
    apb(1'b1, `AFL_OFS_ELIG, 32'h00F, rd, er);
    send('{4'h0, un, 12'h000, 4'h0, AFL_FWD_FLOOD, 9'h00E, 4'h0, 1'b0});
    send('{4'h0, un, 12'h000, 4'h3, AFL_FWD_FLOOD, 9'h007, 4'h0, 1'b0});
    // reset in mid run brings the port sets back to their defaults
    reset_n <= 1'b0;
    @(posedge clk_sys);
    chk("rsp_valid_rst", 1'b0, rsp_valid);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, `AFL_OFS_ELIG, 32'h0, rd, er);
    chk("elig_rst", 32'h1FF, rd);
    send(rows[5]);
    finish_test;
  end
endmodule

bind afl_lookup afl_lookup_asserts #(.NPORT(NPORT), .PORT_W(PORT_W), .IDX_W(IDX_W))
  afl_lookup_asserts_i (.clk_sys, .reset_n, .req_valid, .req_ready, .req_da, .req_src_port,
    .rsp_valid, .rsp_kind, .rsp_port, .rsp_mask, .rsp_tc_valid, .tbl_rd_en, .tbl_rd_idx,
    .tbl_rd_half, .tbl_age_wr);
